// ### hw/smc_map.svh
// constants of the serial microport and mode control block
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ============================================================
// timing
`define SMC_CLK_MHZ        250
`define SMC_SCLK_NS        160
`define SMC_HALF_SCLK_CYC  ((`SMC_SCLK_NS * `SMC_CLK_MHZ) / 2000)
`define SMC_FRAME_GAP_US   250

// ============================================================
// register addresses inside the device
`define SMC_ADDR_STATUS    5'h00
`define SMC_ADDR_CTRL1     5'h01
`define SMC_ADDR_CTRL2     5'h02
`define SMC_CTRL1_RST      8'h00
`define SMC_CTRL2_RST      8'h00

// ============================================================
// first control register fields
`define SMC_C1_BYPASS      0
`define SMC_C1_FREEZE      1
`define SMC_C1_B2B         2
`define SMC_C1_EXTD        3
`define SMC_C1_PAD         4

// second control register fields
`define SMC_C2_RMUTE       0
`define SMC_C2_SMUTE       1

// status register fields
`define SMC_ST_PORT_EN     0
`define SMC_ST_FRAME       1
`define SMC_ST_CFG_LO      2
`define SMC_ST_CFG_HI      3

// ============================================================
// command byte, in arrival order: bit 7 arrives first
`define SMC_CMD_RW_BIT     7
`define SMC_CMD_ADDR_HI    6
`define SMC_CMD_ADDR_LO    2
`define SMC_BYTE_BITS      4'd8
`define SMC_LAST_BIT       4'd15

`endif

// ### hw/smc_pkg.sv
// types and helpers shared by both ends of the serial microport
package smc_pkg;

  // ============================================================
  // configurations and canceller functions
  typedef enum logic [1:0] {
    SMC_CFG_NORMAL = 2'b00,
    SMC_CFG_B2B    = 2'b01,
    SMC_CFG_EXTD   = 2'b10
  } smc_cfg_t;

  typedef enum logic [1:0] {
    SMC_FN_MUTE   = 2'b00,
    SMC_FN_BYPASS = 2'b01,
    SMC_FN_FREEZE = 2'b10,
    SMC_FN_ADAPT  = 2'b11
  } smc_func_t;

  // ============================================================
  // state machines
  typedef enum logic [1:0] {
    SMC_DV_IDLE = 2'b00,
    SMC_DV_CMD  = 2'b01,
    SMC_DV_DATA = 2'b10,
    SMC_DV_DONE = 2'b11
  } smc_dev_st_t;

  typedef enum logic [2:0] {
    SMC_HS_IDLE  = 3'b000,
    SMC_HS_SETUP = 3'b001,
    SMC_HS_LEAD  = 3'b010,
    SMC_HS_LOW   = 3'b011,
    SMC_HS_HIGH  = 3'b100,
    SMC_HS_TRAIL = 3'b101,
    SMC_HS_END   = 3'b110
  } smc_host_st_t;

  // ============================================================
  // bit order swap between wire order and value order
  function automatic logic [7:0] smc_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

endpackage

// ### hw/smc_if.sv
// link between the host controller and the device microport
`timescale 1ns/100ps
interface smc_if;
  logic sclk;
  logic cs_n;
  logic d1_host_o;
  logic d1_host_oe;
  logic d1_dev_o;
  logic d1_dev_oe;
  logic port_rx_line;
  logic port_tx_or_bidir_line;

  // wire level of the shared line, pulled high when nobody drives
  assign port_tx_or_bidir_line = d1_dev_oe ? d1_dev_o : (d1_host_oe ? d1_host_o : 1'b1);

  modport dev  (input sclk, cs_n, port_rx_line, port_tx_or_bidir_line, output d1_dev_o, d1_dev_oe);
  modport host (output sclk, cs_n, port_rx_line, d1_host_o, d1_host_oe, input port_tx_or_bidir_line);
endinterface

// ### hw/smc_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
module smc_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ### hw/smc_device.sv
// device end: serial microport, control registers and function selection
//
// Behaviour
// [R1] port active only when both straps zero
// [R2] sclk high at select: lsb-first, shared line
// [R3] sclk low at select: msb-first, split lines
// [R4] split mode half duplex, inputs ignored on read
// [R5] each transaction is exactly two bytes
// [R6] host holds select low whole transaction
// [R7] first eight clocks carry command/address byte
// [R8] next eight clocks move the data byte
// [R9] select rising releases the data line
// [R10] data bit order follows detected mode
// [R11] command byte layout fixed in arrival order
// [R12] sample on rising, shift out on falling
// [R13] zero straps: registers, else pins
// [R14] straps 11 normal, 10 b2b, 01 ext
// [R15] register bits pick normal, b2b, ext delay
// [R16] pin pairs select mute, bypass, freeze, adapt
// [R17] mute, bypass, freeze from register bits
// [R18] adapt only with freeze and bypass clear
// [R19] attenuator off by pins, register bit else
// [R20] frame pulses select frame bus mode
// [R21] software never sets b2b and ext together
// [R22] command bit positions held as constants
// [R23] short transaction leaves registers unchanged
`timescale 1ns/100ps
`include "smc_map.svh"
module smc_device
  import smc_pkg::*;
#(
  parameter int FRAME_HOLD_CYC = `SMC_FRAME_GAP_US * `SMC_CLK_MHZ
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  smc_if.dev              link,
  input  wire logic       CFG_STRAP_ONE,
  input  wire logic       CFG_STRAP_TWO,
  input  wire logic [1:0] CANCELLER_A_FUNC_PINS,
  input  wire logic [1:0] CANCELLER_B_FUNC_PINS,
  input  wire logic       FRAME_PULSE_IN,
  output logic            PORT_ENABLED,
  output smc_cfg_t        CONFIG_SEL,
  output smc_func_t       FUNC_A,
  output smc_func_t       FUNC_B,
  output logic            ATTENUATOR_ON,
  output logic            FRAME_BUS_MODE
);

  // ============================================================
  // pin synchronisation
  logic [10:0] sync_s;
  logic        sclk_s;
  logic        csn_s;
  logic        d1_s;
  logic        rx_s;
  logic [1:0]  strap_s;
  logic [1:0]  pins_a_s;
  logic [1:0]  pins_b_s;
  logic        fp_s;

  smc_sync #(.WIDTH(11)) u_sync (
    .clk  (CLOCK),
    .rst  (RST),
    .din  ({link.sclk, link.cs_n, link.port_tx_or_bidir_line, link.port_rx_line,
            CFG_STRAP_ONE, CFG_STRAP_TWO, CANCELLER_A_FUNC_PINS, CANCELLER_B_FUNC_PINS,
            FRAME_PULSE_IN}),
    .dout (sync_s)
  );

  assign {sclk_s, csn_s, d1_s, rx_s, strap_s, pins_a_s, pins_b_s, fp_s} = sync_s;

  // ============================================================
  // edge detection on synchronised link pins
  logic sclk_p_q;
  logic csn_p_q;
  logic fp_p_q;

  // previous values for edge finding
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sclk_p_q <= 1'b0;
      csn_p_q  <= 1'b1;
      fp_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      csn_p_q  <= csn_s;
      fp_p_q   <= fp_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall  = csn_p_q & ~csn_s;
  assign cs_rise  = ~csn_p_q & csn_s;
  assign sck_rise = ~sclk_p_q & sclk_s & ~csn_s;
  assign sck_fall = sclk_p_q & ~sclk_s & ~csn_s;

  // ============================================================
  // serial transaction state
  smc_dev_st_t st_q;
  logic        lsb_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        rw_q;
  logic [4:0]  addr_q;
  logic        port_en_q;
  logic        in_bit;
  logic [7:0]  wire_word;
  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  logic [7:0]  rd_val;
  logic        wr_fire;

  assign in_bit    = lsb_q ? d1_s : rx_s;            // see [R2] see [R3]
  assign wire_word = {sh_q[6:0], in_bit};
  // commit only on the sixteenth rising edge of a write
  assign wr_fire   = sck_rise & (st_q == SMC_DV_DATA) & (cnt_q == `SMC_LAST_BIT) & ~rw_q;   // see [R23]

  // mode capture, bit count and phase
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_q   <= SMC_DV_IDLE;
      lsb_q  <= 1'b0;
      cnt_q  <= 4'h0;
      rw_q   <= 1'b0;
      addr_q <= 5'h00;
    end else if (!port_en_q || csn_s) begin
      st_q   <= SMC_DV_IDLE;                         // see [R6] see [R23]
    end else if (cs_fall) begin
      st_q   <= SMC_DV_CMD;
      lsb_q  <= sclk_s;                              // see [R2] see [R3]
      cnt_q  <= 4'h0;
    end else if (sck_rise && (st_q == SMC_DV_CMD || st_q == SMC_DV_DATA)) begin
      cnt_q  <= cnt_q + 4'h1;
      if (cnt_q == `SMC_BYTE_BITS - 4'h1) begin
        st_q   <= SMC_DV_DATA;                       // see [R7]
        rw_q   <= wire_word[`SMC_CMD_RW_BIT];        // see [R11] see [R22]
        addr_q <= wire_word[`SMC_CMD_ADDR_HI:`SMC_CMD_ADDR_LO];
      end else if (cnt_q == `SMC_LAST_BIT) begin
        st_q   <= SMC_DV_DONE;                       // see [R5] see [R8]
      end
    end
  end

  // receive shifter, not moved during the read data byte
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sh_q <= 8'h00;
    end else if (sck_rise && (st_q == SMC_DV_CMD || (st_q == SMC_DV_DATA && !rw_q))) begin
      sh_q <= wire_word;                             // see [R12] see [R4]
    end
  end

  // ============================================================
  // transmit side of the data line
  logic       d1_o_q;
  logic       d1_oe_q;
  logic       tx_ld_q;
  logic [7:0] tx_q;
  logic [7:0] tx_wire;

  assign tx_wire = lsb_q ? smc_rev8(rd_val) : rd_val;   // see [R10]

  // drive from select fall in split mode, else on falling sclk; release whenever select is high
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      d1_o_q  <= 1'b0;
      d1_oe_q <= 1'b0;
      tx_ld_q <= 1'b0;
      tx_q    <= 8'h00;
    end else if (!port_en_q || csn_s || cs_rise) begin
      d1_oe_q <= 1'b0;                               // see [R9]
      tx_ld_q <= 1'b0;
    end else if (cs_fall) begin
      d1_o_q  <= 1'b0;
      d1_oe_q <= ~sclk_s;                            // see [R3]
      tx_ld_q <= 1'b0;
    end else if (sck_fall && st_q == SMC_DV_DATA && rw_q) begin
      d1_oe_q <= 1'b1;                               // see [R8]
      if (!tx_ld_q) begin
        d1_o_q  <= tx_wire[7];                       // see [R12]
        tx_q    <= {tx_wire[6:0], 1'b0};
        tx_ld_q <= 1'b1;
      end else begin
        d1_o_q  <= tx_q[7];
        tx_q    <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign link.d1_dev_o  = d1_o_q;
  assign link.d1_dev_oe = d1_oe_q;

  // ============================================================
  // control registers
  logic [7:0] wr_val;
  assign wr_val = lsb_q ? smc_rev8(wire_word) : wire_word;   // see [R10]

  // writes land only after a full two-byte write
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl1_q <= `SMC_CTRL1_RST;
      ctrl2_q <= `SMC_CTRL2_RST;
    end else if (wr_fire && port_en_q) begin
      if (addr_q == `SMC_ADDR_CTRL1) begin
        ctrl1_q <= wr_val;
      end
      if (addr_q == `SMC_ADDR_CTRL2) begin
        ctrl2_q <= wr_val;
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    case (addr_q)
      `SMC_ADDR_STATUS: begin
        rd_val[`SMC_ST_PORT_EN]              = port_en_q;
        rd_val[`SMC_ST_FRAME]                = FRAME_BUS_MODE;
        rd_val[`SMC_ST_CFG_HI:`SMC_ST_CFG_LO] = CONFIG_SEL;
      end
      `SMC_ADDR_CTRL1: rd_val = ctrl1_q;
      `SMC_ADDR_CTRL2: rd_val = ctrl2_q;
      default: rd_val = 8'h00;
    endcase
  end

  // ============================================================
  // function selection
  smc_cfg_t  cfg_d;
  smc_func_t reg_fn;
  logic      ctl_mode;

  assign ctl_mode = (strap_s == 2'b00);              // see [R1] see [R13]

  always_comb begin
    // configuration, back-to-back wins if software sets both
    if (ctl_mode) begin
      if (ctrl1_q[`SMC_C1_B2B]) begin
        cfg_d = SMC_CFG_B2B;                         // see [R15] see [R21]
      end else if (ctrl1_q[`SMC_C1_EXTD]) begin
        cfg_d = SMC_CFG_EXTD;
      end else begin
        cfg_d = SMC_CFG_NORMAL;
      end
    end else begin
      case (strap_s)
        2'b11:   cfg_d = SMC_CFG_NORMAL;             // see [R14]
        2'b10:   cfg_d = SMC_CFG_B2B;
        2'b01:   cfg_d = SMC_CFG_EXTD;
        default: cfg_d = SMC_CFG_NORMAL;
      endcase
    end
    // register-driven canceller function
    if (ctrl2_q[`SMC_C2_RMUTE] || ctrl2_q[`SMC_C2_SMUTE]) begin
      reg_fn = SMC_FN_MUTE;                          // see [R17]
    end else if (ctrl1_q[`SMC_C1_BYPASS]) begin
      reg_fn = SMC_FN_BYPASS;
    end else if (ctrl1_q[`SMC_C1_FREEZE]) begin
      reg_fn = SMC_FN_FREEZE;
    end else begin
      reg_fn = SMC_FN_ADAPT;                         // see [R18]
    end
  end

  // registered function outputs
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      port_en_q     <= 1'b0;
      CONFIG_SEL    <= SMC_CFG_NORMAL;
      FUNC_A        <= SMC_FN_ADAPT;
      FUNC_B        <= SMC_FN_ADAPT;
      ATTENUATOR_ON <= 1'b0;
    end else begin
      port_en_q     <= ctl_mode;                     // see [R1]
      CONFIG_SEL    <= cfg_d;
      FUNC_A        <= ctl_mode ? reg_fn : smc_func_t'(pins_a_s);   // see [R16] see [R13]
      FUNC_B        <= ctl_mode ? reg_fn : smc_func_t'(pins_b_s);
      ATTENUATOR_ON <= ctl_mode & ctrl1_q[`SMC_C1_PAD];             // see [R19]
    end
  end

  assign PORT_ENABLED = port_en_q;

  // ============================================================
  // frame pulse watch: a pulse selects frame bus, long low selects strobe bus
  logic [16:0] fp_cnt_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      fp_cnt_q       <= 17'h00000;
      FRAME_BUS_MODE <= 1'b0;
    end else if (fp_s && !fp_p_q) begin
      fp_cnt_q       <= 17'h00000;
      FRAME_BUS_MODE <= 1'b1;                        // see [R20]
    end else if (!fp_s) begin
      if (fp_cnt_q == 17'(FRAME_HOLD_CYC)) begin
        FRAME_BUS_MODE <= 1'b0;                      // see [R20]
      end else begin
        fp_cnt_q <= fp_cnt_q + 17'h00001;
      end
    end
  end

endmodule

// ### hw/smc_host.sv
// host end: drives two-byte transactions over the microport
`timescale 1ns/100ps
`include "smc_map.svh"
module smc_host
  import smc_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  smc_if.host             link,
  input  wire logic       CMD_START,
  input  wire logic       CMD_READ,
  input  wire logic [4:0] CMD_ADDR,
  input  wire logic [7:0] CMD_WDATA,
  input  wire logic       CMD_LSB_FIRST,
  output logic            BUSY,
  output logic            DONE,
  output logic [7:0]      RDATA
);

  localparam logic [7:0] HALF_M1 = 8'(`SMC_HALF_SCLK_CYC - 1);

  // ============================================================
  // half-period divider, one-cycle enable per sclk phase
  smc_host_st_t st_q;
  logic [7:0]   tmr_q;
  logic         tick;

  assign tick = (tmr_q == HALF_M1);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tmr_q <= 8'h00;
    end else if (st_q == SMC_HS_IDLE || tick) begin
      tmr_q <= 8'h00;
    end else begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  // ============================================================
  // transaction sequencer
  logic        sclk_q;
  logic        csn_q;
  logic        dout_q;
  logic        oe_q;
  logic        lsb_q;
  logic        rd_q;
  logic [15:0] sh_q;
  logic [7:0]  rx_q;
  logic [3:0]  bit_q;
  logic [7:0]  cmd_w;

  // command byte in arrival order, read flag first
  always_comb begin
    cmd_w = 8'h00;
    cmd_w[`SMC_CMD_RW_BIT]                     = CMD_READ;
    cmd_w[`SMC_CMD_ADDR_HI:`SMC_CMD_ADDR_LO]  = CMD_ADDR;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_q   <= SMC_HS_IDLE;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
      lsb_q  <= 1'b0;
      rd_q   <= 1'b0;
      sh_q   <= 16'h0000;
      rx_q   <= 8'h00;
      bit_q  <= 4'h0;
      BUSY   <= 1'b0;
      DONE   <= 1'b0;
      RDATA  <= 8'h00;
    end else begin
      DONE <= 1'b0;
      case (st_q)
        SMC_HS_IDLE: begin
          if (CMD_START) begin
            st_q   <= SMC_HS_SETUP;
            lsb_q  <= CMD_LSB_FIRST;
            rd_q   <= CMD_READ;
            sclk_q <= CMD_LSB_FIRST;                 // idle level picks the mode
            sh_q   <= {cmd_w, CMD_LSB_FIRST ? smc_rev8(CMD_WDATA) : CMD_WDATA};
            bit_q  <= 4'h0;
            BUSY   <= 1'b1;
          end
        end
        SMC_HS_SETUP: if (tick) begin
          st_q  <= SMC_HS_LEAD;
          csn_q <= 1'b0;                             // see [R6]
        end
        SMC_HS_LEAD: if (tick) begin
          st_q   <= SMC_HS_LOW;
          sclk_q <= 1'b0;
          dout_q <= sh_q[15];
          oe_q   <= lsb_q;
        end
        SMC_HS_LOW: if (tick) begin
          st_q   <= SMC_HS_HIGH;
          sclk_q <= 1'b1;
          rx_q   <= {rx_q[6:0], link.port_tx_or_bidir_line};
          sh_q   <= {sh_q[14:0], 1'b0};
        end
        SMC_HS_HIGH: if (tick) begin
          bit_q <= bit_q + 4'h1;
          if (bit_q == `SMC_LAST_BIT) begin
            st_q   <= SMC_HS_TRAIL;
            sclk_q <= lsb_q;
            oe_q   <= 1'b0;
          end else begin
            st_q   <= SMC_HS_LOW;
            sclk_q <= 1'b0;
            dout_q <= sh_q[15];
            // shared line is handed to the device for a read data byte
            oe_q   <= lsb_q & ~(rd_q & (bit_q >= `SMC_BYTE_BITS - 4'h1));
          end
        end
        SMC_HS_TRAIL: if (tick) begin
          st_q  <= SMC_HS_END;
          csn_q <= 1'b1;
        end
        SMC_HS_END: if (tick) begin
          st_q  <= SMC_HS_IDLE;
          BUSY  <= 1'b0;
          DONE  <= 1'b1;
          RDATA <= lsb_q ? smc_rev8(rx_q) : rx_q;
        end
        default: st_q <= SMC_HS_IDLE;
      endcase
    end
  end

  assign link.sclk         = sclk_q;
  assign link.cs_n         = csn_q;
  assign link.d1_host_o    = dout_q;
  assign link.d1_host_oe   = oe_q;
  assign link.port_rx_line = dout_q;

endmodule

// ### test/smc_monitor.sv
// checker watching the microport wires between host and device ends
`timescale 1ns/100ps
module smc_monitor (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic d1_host_o,
  input wire logic d1_host_oe,
  input wire logic d1_dev_o,
  input wire logic d1_dev_oe,
  input wire logic port_rx_line,
  input wire logic port_tx_or_bidir_line
);
  default clocking mon_cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // ============================================================
  // helper: serial clock rising edges inside one selection
  logic       sclk_q;
  logic [4:0] rises_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sclk_q  <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rises_q <= 5'h00;
      end else if (sclk && !sclk_q) begin
        rises_q <= rises_q + 5'h01;
      end
    end
  end

  // ============================================================
  // sequences and assertions
  sequence s_deselect;
    $rose(cs_n);
  endsequence

  sequence s_quiet_line;
    !d1_dev_oe [*4];
  endsequence

  chk_release_line: assert property (s_deselect |-> ##[1:4] s_quiet_line)
    else $error("data line still driven after deselect");
  chk_idle_undriven: assert property (cs_n [*6] |-> !d1_dev_oe)
    else $error("device drives data line while deselected");
  chk_no_contention: assert property (!(d1_dev_oe && d1_host_oe))
    else $error("host and device drive shared line together");
  chk_out_on_fall: assert property (d1_dev_oe && !cs_n && $changed(d1_dev_o) |-> !sclk)
    else $error("device output changed while serial clock high");
  chk_sixteen_clk: assert property (s_deselect |-> rises_q == 5'h10)
    else $error("selection did not carry sixteen clock cycles");
  chk_deselect_gap: assert property (s_deselect |-> cs_n [*4])
    else $error("deselect gap too short");
  chk_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock phase too short");
  chk_mode_steady: assert property ($fell(cs_n) |-> $stable(sclk) [*4])
    else $error("serial clock moved around select edge");

  cover property ($fell(cs_n) && sclk);
  cover property ($fell(cs_n) && !sclk);
endmodule

// ### test/tb_top.sv
// self-checking bench joining host and device ends of the microport
`timescale 1ns/100ps
`include "smc_map.svh"
module tb_top
  import smc_pkg::*;
;
  logic        clock, rst, start, rd, lsb, s_one, s_two, frame;
  logic [4:0]  addr;
  logic [7:0]  wdata, rd_q;
  logic [1:0]  pins_a;
  logic        busy, done, port_en, att_on, frame_mode, lsb_seen;
  logic [7:0]  rdata;
  logic [15:0] wire_bits;
  smc_cfg_t    cfg;
  smc_func_t   fa, fb;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  c1v [6] = '{8'h00, 8'h04, 8'h08, 8'h01, 8'h02, 8'h10};
  smc_cfg_t    cv [6] = '{SMC_CFG_NORMAL, SMC_CFG_B2B, SMC_CFG_EXTD, SMC_CFG_NORMAL, SMC_CFG_NORMAL, SMC_CFG_NORMAL};
  smc_func_t   fv [6] = '{SMC_FN_ADAPT, SMC_FN_ADAPT, SMC_FN_ADAPT, SMC_FN_BYPASS, SMC_FN_FREEZE, SMC_FN_ADAPT};
  smc_cfg_t    pcfg [4] = '{SMC_CFG_NORMAL, SMC_CFG_EXTD, SMC_CFG_B2B, SMC_CFG_NORMAL};

  // ============================================================
  // clock, timeout and the two ends
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  smc_if smc_if_i ();
  smc_device #(.FRAME_HOLD_CYC(200)) smc_device_i (
    .CLOCK(clock), .RST(rst), .link(smc_if_i), .CFG_STRAP_ONE(s_one), .CFG_STRAP_TWO(s_two),
    .CANCELLER_A_FUNC_PINS(pins_a), .CANCELLER_B_FUNC_PINS(~pins_a), .FRAME_PULSE_IN(frame),
    .PORT_ENABLED(port_en), .CONFIG_SEL(cfg), .FUNC_A(fa), .FUNC_B(fb), .ATTENUATOR_ON(att_on),
    .FRAME_BUS_MODE(frame_mode));
  smc_host smc_host_i (
    .CLOCK(clock), .RST(rst), .link(smc_if_i), .CMD_START(start), .CMD_READ(rd), .CMD_ADDR(addr),
    .CMD_WDATA(wdata), .CMD_LSB_FIRST(lsb), .BUSY(busy), .DONE(done), .RDATA(rdata));
  smc_monitor smc_monitor_i (
    .CLOCK(clock), .RST(rst), .sclk(smc_if_i.sclk), .cs_n(smc_if_i.cs_n), .d1_host_o(smc_if_i.d1_host_o),
    .d1_host_oe(smc_if_i.d1_host_oe), .d1_dev_o(smc_if_i.d1_dev_o), .d1_dev_oe(smc_if_i.d1_dev_oe),
    .port_rx_line(smc_if_i.port_rx_line), .port_tx_or_bidir_line(smc_if_i.port_tx_or_bidir_line));

  // wire snoop: mode at select and bits as sampled on rising clock
  always @(negedge smc_if_i.cs_n) begin
    lsb_seen = smc_if_i.sclk;
  end
  always @(posedge smc_if_i.sclk) begin
    if (!smc_if_i.cs_n) begin
      wire_bits <= {wire_bits[14:0], lsb_seen ? smc_if_i.port_tx_or_bidir_line : smc_if_i.port_rx_line};
    end
  end

  // ============================================================
  // tasks
  function automatic logic [7:0] flip(input logic [7:0] v);
    for (int i = 0; i < 8; i++) flip[i] = v[7-i];
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    start <= 1'b1;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    check("busy", {7'h00, busy}, 8'h01);
    while (done !== 1'b1 && n < 800) begin
      @(negedge clock);
      n++;
    end
    if (n == 800) fails++;
    rd_q = rdata;
    check("busy end", {7'h00, busy}, 8'h00);
    check("line idle", {7'h00, smc_if_i.port_tx_or_bidir_line}, 8'h01);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
    check("mode", {7'h00, lsb_seen}, {7'h00, lsb});
    check("cmd byte", wire_bits[15:8], {1'b0, a, 2'b00});
    check("data bits", wire_bits[7:0], lsb ? flip(d) : d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp, input string what);
    xfer(1'b1, a, 8'h00);
    check(what, rd_q, exp);
  endtask

  task automatic outs(input smc_cfg_t c, input smc_func_t a, input smc_func_t b, input logic at, input logic en);
    repeat (8) @(posedge clock);
    check("config", {6'h00, cfg}, {6'h00, c});
    check("func a", {6'h00, fa}, {6'h00, a});
    check("func b", {6'h00, fb}, {6'h00, b});
    check("atten", {7'h00, att_on}, {7'h00, at});
    check("port on", {7'h00, port_en}, {7'h00, en});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial begin
    {rst, start, rd, lsb, s_one, s_two, frame, lsb_seen} = 8'h80;
    {addr, wdata, pins_a, wire_bits} = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    outs(SMC_CFG_NORMAL, SMC_FN_ADAPT, SMC_FN_ADAPT, 1'b0, 1'b1);
    // register control in both host modes
    for (int m = 0; m < 2; m++) begin
      lsb <= m[0];
      for (int i = 0; i < 6; i++) begin
        wr(`SMC_ADDR_CTRL1, c1v[i]);
        outs(cv[i], fv[i], fv[i], c1v[i][4], 1'b1);
        rdc(`SMC_ADDR_CTRL1, c1v[i], "ctrl1");
      end
      for (int j = 1; j < 3; j++) begin
        wr(`SMC_ADDR_CTRL2, j[7:0]);
        outs(SMC_CFG_NORMAL, SMC_FN_MUTE, SMC_FN_MUTE, 1'b1, 1'b1);
        rdc(`SMC_ADDR_CTRL2, j[7:0], "ctrl2");
      end
      wr(`SMC_ADDR_CTRL2, 8'h00);
      wr(`SMC_ADDR_STATUS, 8'hff);
      rdc(`SMC_ADDR_STATUS, 8'h01, "status");
      rdc(5'h1f, 8'h00, "unmapped");
    end
    // pin control for every strap set and select pair
    for (int k = 1; k < 4; k++) begin
      {s_one, s_two} <= k[1:0];
      for (int p = 0; p < 4; p++) begin
        pins_a <= p[1:0];
        outs(pcfg[k], smc_func_t'(p[1:0]), smc_func_t'(~p[1:0]), 1'b0, 1'b0);
      end
    end
    wr(`SMC_ADDR_CTRL1, 8'h04);
    {s_one, s_two} <= 2'b00;
    outs(SMC_CFG_NORMAL, SMC_FN_ADAPT, SMC_FN_ADAPT, 1'b1, 1'b1);
    rdc(`SMC_ADDR_CTRL1, 8'h10, "ctrl1 kept");
    // frame pulse selects frame bus, long low returns to strobe bus
    frame <= 1'b1;
    @(posedge clock);
    frame <= 1'b0;
    repeat (8) @(posedge clock);
    check("frame mode", {7'h00, frame_mode}, 8'h01);
    repeat (230) @(posedge clock);
    check("strobe mode", {7'h00, frame_mode}, 8'h00);
    report_and_stop();
  end
endmodule
